/* pkg/combo_host_pkg.sv */
package combo_host_pkg;
  localparam int FLASH_AW          = 20;
  localparam int SRAM_AW           = 17;
  localparam int DATA_W            = 8;
  localparam int CLK_PERIOD_NS     = 100;
  localparam int RESET_HOLD_NS     = 100;
  // Strictly more than the hold time, rounded up
  localparam int RESET_HOLD_CYC    = RESET_HOLD_NS / CLK_PERIOD_NS + 1;
  localparam int ACCESS_NS         = 200;
  localparam int ACCESS_CYC        = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W             = 8;
  // Flops between the data pins and the read capture
  localparam int SYNC_STAGES       = 2;
  localparam logic [1:0] OP_FLASH_READ  = 2'h0;
  localparam logic [1:0] OP_FLASH_WRITE = 2'h1;
  localparam logic [1:0] OP_SRAM_READ   = 2'h2;
  localparam logic [1:0] OP_SRAM_WRITE  = 2'h3;
endpackage : combo_host_pkg

/* design/combo_host_ctrl.sv */
`timescale 1ns/1ns
module combo_host_ctrl
  import combo_host_pkg::*;
#(
  parameter int ACC_CYC  = ACCESS_CYC,
  parameter int HOLD_CYC = RESET_HOLD_CYC
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                flash_supply_good,
  input  wire logic                flash_power_off_req,
  input  wire logic                req_valid,
  input  wire logic [1:0]          req_op,
  input  wire logic [FLASH_AW-1:0] req_addr,
  input  wire logic [DATA_W-1:0]   req_wdata,
  output logic                     req_ready,
  output logic                     rsp_valid,
  output logic [DATA_W-1:0]        rsp_rdata,
  output logic                     flash_ready,
  output logic [FLASH_AW-1:0]      mem_addr,
  output logic                     flash_ce_n,
  output logic                     flash_oe_n,
  output logic                     flash_we_n,
  output logic                     sram_ce_n,
  output logic                     sram_oe_n,
  output logic                     sram_we_n,
  output logic                     flash_reset_powerdown_n,
  output logic [DATA_W-1:0]        data_out,
  output logic                     data_oe,
  input  wire logic [DATA_W-1:0]   data_in
);

  typedef enum logic [2:0] {ST_PWR, ST_IDLE, ST_ACCESS, ST_END, ST_DOWN} state_t;

  state_t                state_ff, nxt_state;
  logic [CNT_W-1:0]      cnt_ff, nxt_cnt;
  logic [1:0]            op_ff, nxt_op;
  logic [FLASH_AW-1:0]   addr_ff, nxt_addr;
  logic [DATA_W-1:0]     wd_ff, nxt_wd, rd_ff, nxt_rd;
  logic                  fce_ff, foe_ff, fwe_ff, sce_ff, soe_ff, swe_ff, rp_ff, doe_ff;
  logic                  nxt_fce, nxt_foe, nxt_fwe, nxt_sce, nxt_soe, nxt_swe, nxt_rp, nxt_doe;
  logic                  rdy_ff, nxt_rdy, rv_ff, nxt_rv, fr_ff, nxt_fr;
  logic                  good_s1_ff, good_s2_ff, off_s1_ff, off_s2_ff;
  logic [DATA_W-1:0]     din_s1_ff, din_s2_ff;

  // Pins from outside the clock domain pass two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      good_s1_ff <= 1'b0;
      good_s2_ff <= 1'b0;
      off_s1_ff  <= 1'b0;
      off_s2_ff  <= 1'b0;
      din_s1_ff  <= 8'h00;
      din_s2_ff  <= 8'h00;
    end else begin
      good_s1_ff <= flash_supply_good;
      good_s2_ff <= good_s1_ff;
      off_s1_ff  <= flash_power_off_req;
      off_s2_ff  <= off_s1_ff;
      din_s1_ff  <= data_in;
      din_s2_ff  <= din_s1_ff;
    end
  end

  function automatic logic is_flash(input logic [1:0] op);
    return (op == OP_FLASH_READ) || (op == OP_FLASH_WRITE);
  endfunction : is_flash

  function automatic logic is_write(input logic [1:0] op);
    return (op == OP_FLASH_WRITE) || (op == OP_SRAM_WRITE);
  endfunction : is_write

  // Access length in cycles; reads pay for the pin synchroniser
  function automatic logic [CNT_W-1:0] acc_len(input logic [1:0] op);
    return is_write(op) ? CNT_W'(ACC_CYC) : CNT_W'(ACC_CYC + SYNC_STAGES);
  endfunction : acc_len

  // Sequencer: power-up hold, one access at a time, power-down park
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_op    = op_ff;
    nxt_addr  = addr_ff;
    nxt_wd    = wd_ff;
    nxt_rd    = rd_ff;
    nxt_fce   = 1'b1;
    nxt_foe   = 1'b1;
    nxt_fwe   = 1'b1;
    nxt_sce   = 1'b1;
    nxt_soe   = 1'b1;
    nxt_swe   = 1'b1;
    nxt_doe   = 1'b0;
    nxt_rp    = rp_ff;
    nxt_rdy   = 1'b0;
    nxt_rv    = 1'b0;
    nxt_fr    = fr_ff;
    unique case (state_ff)
      ST_PWR: begin
        nxt_rp = 1'b0;
        nxt_fr = 1'b0;
        if (!good_s2_ff) begin
          nxt_cnt = '0;
        end else if (cnt_ff >= CNT_W'(HOLD_CYC)) begin
          nxt_rp    = 1'b1;
          nxt_fr    = 1'b1;
          nxt_rdy   = 1'b1;
          nxt_state = ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff + CNT_W'(1);
        end
      end
      ST_IDLE: begin
        nxt_rdy = 1'b1;
        if (off_s2_ff || !good_s2_ff) begin
          nxt_rp    = 1'b0;
          nxt_fr    = 1'b0;
          nxt_rdy   = 1'b0;
          nxt_state = ST_DOWN;
        end else if (req_valid && rdy_ff && !(is_flash(req_op) && !fr_ff)) begin
          nxt_op    = req_op;
          nxt_addr  = is_flash(req_op) ? req_addr
                                       : {{(FLASH_AW-SRAM_AW){1'b0}}, req_addr[SRAM_AW-1:0]};
          nxt_wd    = req_wdata;
          nxt_cnt   = '0;
          nxt_rdy   = 1'b0;
          nxt_state = ST_ACCESS;
          // Exactly one chip enable, never both
          nxt_fce = !is_flash(req_op);
          nxt_sce = is_flash(req_op);
          nxt_foe = (req_op != OP_FLASH_READ);
          nxt_fwe = (req_op != OP_FLASH_WRITE);
          nxt_soe = (req_op != OP_SRAM_READ);
          nxt_swe = (req_op != OP_SRAM_WRITE);
          nxt_doe = is_write(req_op);
        end
      end
      ST_ACCESS: begin
        nxt_fce = !is_flash(op_ff);
        nxt_sce = is_flash(op_ff);
        nxt_foe = (op_ff != OP_FLASH_READ);
        nxt_fwe = (op_ff != OP_FLASH_WRITE);
        nxt_soe = (op_ff != OP_SRAM_READ);
        nxt_swe = (op_ff != OP_SRAM_WRITE);
        nxt_doe = doe_ff;
        nxt_cnt = cnt_ff + CNT_W'(1);
        // Reads stay open longer so the byte seen at the pins after the
        // access time has crossed both sync flops before it is taken
        if (cnt_ff + CNT_W'(1) >= acc_len(op_ff)) begin
          // Write enable rises here while address and data still stand
          nxt_fwe   = 1'b1;
          nxt_swe   = 1'b1;
          nxt_rd    = din_s2_ff;
          nxt_state = ST_END;
        end
      end
      ST_END: begin
        // Enables dropped; data held one more cycle past the write edge
        nxt_rv    = 1'b1;
        nxt_rdy   = 1'b1;
        nxt_state = ST_IDLE;
      end
      ST_DOWN: begin
        nxt_rp = 1'b0;
        if (!off_s2_ff && good_s2_ff) begin
          nxt_cnt   = '0;
          nxt_state = ST_PWR;
        end
      end
      default: nxt_state = ST_PWR;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_PWR;
      cnt_ff   <= '0;
      op_ff    <= OP_FLASH_READ;
      addr_ff  <= '0;
      wd_ff    <= 8'h00;
      rd_ff    <= 8'h00;
      fce_ff   <= 1'b1;
      foe_ff   <= 1'b1;
      fwe_ff   <= 1'b1;
      sce_ff   <= 1'b1;
      soe_ff   <= 1'b1;
      swe_ff   <= 1'b1;
      rp_ff    <= 1'b0;
      doe_ff   <= 1'b0;
      rdy_ff   <= 1'b0;
      rv_ff    <= 1'b0;
      fr_ff    <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      op_ff    <= nxt_op;
      addr_ff  <= nxt_addr;
      wd_ff    <= nxt_wd;
      rd_ff    <= nxt_rd;
      fce_ff   <= nxt_fce;
      foe_ff   <= nxt_foe;
      fwe_ff   <= nxt_fwe;
      sce_ff   <= nxt_sce;
      soe_ff   <= nxt_soe;
      swe_ff   <= nxt_swe;
      rp_ff    <= nxt_rp;
      doe_ff   <= nxt_doe;
      rdy_ff   <= nxt_rdy;
      rv_ff    <= nxt_rv;
      fr_ff    <= nxt_fr;
    end
  end

  assign req_ready               = rdy_ff;
  assign rsp_valid               = rv_ff;
  assign rsp_rdata               = rd_ff;
  assign flash_ready             = fr_ff;
  assign mem_addr                = addr_ff;
  assign flash_ce_n              = fce_ff;
  assign flash_oe_n              = foe_ff;
  assign flash_we_n              = fwe_ff;
  assign sram_ce_n               = sce_ff;
  assign sram_oe_n               = soe_ff;
  assign sram_we_n               = swe_ff;
  assign flash_reset_powerdown_n = rp_ff;
  assign data_out                = wd_ff;
  assign data_oe                 = doe_ff;

  AST_ONE_CE: assert property (@(posedge clk) disable iff (!rst_n)
    fce_ff || sce_ff) else $error("both chip enables low");
  AST_OE_WE: assert property (@(posedge clk) disable iff (!rst_n)
    foe_ff || fwe_ff) else $error("flash oe and we both low");
  AST_NO_DRIVE_READ: assert property (@(posedge clk) disable iff (!rst_n)
    (!foe_ff || !soe_ff) |-> !doe_ff) else $error("bus driven during read");
  AST_RP_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rp_ff) |-> $past(good_s2_ff, 2)) else $error("reset released early");
  AST_RP_DOWN: assert property (@(posedge clk) disable iff (!rst_n)
    (state_ff == ST_DOWN) |-> !rp_ff) else $error("reset high in power down");
  AST_FLASH_ACC_RP: assert property (@(posedge clk) disable iff (!rst_n)
    !fce_ff |-> rp_ff) else $error("flash access with reset low");
  AST_WE_DATA: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(fwe_ff) |-> doe_ff && $stable(addr_ff)) else $error("data lost at write edge");
  AST_SRAM_ADDR: assert property (@(posedge clk) disable iff (!rst_n)
    !sce_ff |-> addr_ff[FLASH_AW-1:SRAM_AW] == '0) else $error("upper address on sram");
endmodule : combo_host_ctrl

/* verification/combo_mem_model.sv */
`timescale 1ns/1ns
module combo_mem_model
  import combo_host_pkg::*;
(
  input  wire logic                clk,
  input  wire logic [FLASH_AW-1:0] addr,
  input  wire logic                f_ce_n,
  input  wire logic                f_oe_n,
  input  wire logic                f_we_n,
  input  wire logic                s_ce_n,
  input  wire logic                s_oe_n,
  input  wire logic                s_we_n,
  input  wire logic                rp_n,
  input  wire logic                lock,
  input  wire logic [DATA_W-1:0]   dout,
  input  wire logic                doe,
  output logic [DATA_W-1:0]        din,
  output int                       viol
);
  logic [DATA_W-1:0] fmem [int];
  logic [DATA_W-1:0] smem [int];
  logic              f_rd;
  logic              s_rd;
  int                sa;
  assign f_rd = !f_ce_n && !f_oe_n && f_we_n && rp_n && s_ce_n;
  assign s_rd = f_ce_n && !s_ce_n && !s_oe_n && s_we_n;
  assign sa = int'(addr[SRAM_AW-1:0]);
  initial viol = 0;
  initial din = 8'h00;
  // Bus settles off the host edge; a floating bus toggles so stale data never passes
  always @(negedge clk) begin
    if (f_rd) din <= fmem.exists(addr) ? fmem[addr] : 8'hFF;
    else if (s_rd) din <= smem.exists(sa) ? smem[sa] : 8'h00;
    else if (doe) din <= dout;
    else din <= ~din;
    if ((!f_ce_n && !s_ce_n) || (!f_oe_n && !f_we_n) || (doe && (f_rd || s_rd)) ||
        (((!f_we_n && !f_ce_n) || (!s_we_n && !s_ce_n)) && !doe))
      viol <= viol + 1;
  end
  // Flash latches on the rising write edge; lockout or reset blocks it
  always @(posedge f_we_n)
    if (!f_ce_n && f_oe_n && rp_n && s_ce_n && !lock) fmem[addr] = dout;
  // SRAM write ignores its output enable
  always @(posedge s_we_n)
    if (!s_ce_n && f_ce_n) smem[sa] = dout;
endmodule : combo_mem_model

/* verification/tb.sv */
`timescale 1ns/1ns
module tb;
  import combo_host_pkg::*;
  typedef struct packed {
    logic [1:0] op; logic [19:0] a; logic [7:0] wd; logic lk; logic [7:0] ex;
  } row_t;
  logic clk, rst_n, flash_supply_good, flash_power_off_req, req_valid, req_ready, rsp_valid;
  logic flash_ready, flash_ce_n, flash_oe_n, flash_we_n, sram_ce_n, sram_oe_n, sram_we_n;
  logic flash_reset_powerdown_n, data_oe, lock;
  logic [1:0] req_op;
  logic [19:0] req_addr, mem_addr;
  logic [7:0] req_wdata, rsp_rdata, data_out, data_in;
  int viol, error_cnt, num_checks, cyc, n;
  // Writes and reads interleaved; lockout and upper flash address cases included
  row_t rows [10] = '{'{2'h3, 20'h00123, 8'hA5, 1'b0, 8'h00}, '{2'h2, 20'h00123, 8'h00, 1'b0, 8'hA5},
    '{2'h1, 20'hA0123, 8'h3C, 1'b0, 8'h00}, '{2'h0, 20'hA0123, 8'h00, 1'b0, 8'h3C},
    '{2'h2, 20'h00123, 8'h00, 1'b0, 8'hA5}, '{2'h0, 20'h00123, 8'h00, 1'b0, 8'hFF},
    '{2'h1, 20'h00456, 8'h77, 1'b1, 8'h00}, '{2'h0, 20'h00456, 8'h00, 1'b1, 8'hFF},
    '{2'h3, 20'h1FFFF, 8'h5A, 1'b0, 8'h00}, '{2'h2, 20'h1FFFF, 8'h00, 1'b0, 8'h5A}};
  combo_host_ctrl dut_u (.clk, .rst_n, .flash_supply_good, .flash_power_off_req, .req_valid,
    .req_op, .req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .flash_ready,
    .mem_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .sram_ce_n, .sram_oe_n, .sram_we_n,
    .flash_reset_powerdown_n, .data_out, .data_oe, .data_in);
  combo_mem_model partner_u (.clk(clk), .addr(mem_addr), .f_ce_n(flash_ce_n),
    .f_oe_n(flash_oe_n), .f_we_n(flash_we_n), .s_ce_n(sram_ce_n), .s_oe_n(sram_oe_n),
    .s_we_n(sram_we_n), .rp_n(flash_reset_powerdown_n), .lock(lock), .dout(data_out),
    .doe(data_oe), .din(data_in), .viol(viol));
  always #50 clk = ~clk;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("Checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  // One access, driven at falling edges; the answer has a fixed latency
  task automatic access(input row_t r);
    int k;
    {req_op, req_addr, req_wdata, lock, req_valid} = {r.op, r.a, r.wd, r.lk, 1'b1};
    k = 0;
    while (!(req_ready && (r.op[1] || flash_ready)) && k < 50) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    req_valid = 1'b0;
    k = 1;
    while (rsp_valid !== 1'b1 && k < 30) begin
      @(negedge clk);
      k++;
    end
    check("latency", k, ACCESS_CYC + 2 + (r.op[0] ? 0 : SYNC_STAGES));
    if (!r.op[0]) check("rdata", rsp_rdata, r.ex);
    @(negedge clk);
    check("bus_idle", {data_oe, flash_ce_n, sram_ce_n}, 3'h3);
    lock = 1'b0;
  endtask : access
  task automatic wait_flash();
    n = 0;
    while (flash_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    check("flash_ready", flash_ready, 1);
  endtask : wait_flash
  // Ceiling well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    {clk, rst_n, flash_supply_good, flash_power_off_req, req_valid, lock} = 6'h00;
    {req_op, req_addr, req_wdata} = 30'h0;
    repeat (3) @(negedge clk);
    // In reset: reset pin low, every strobe released, nothing offered
    check("reset_pins", {flash_reset_powerdown_n, req_ready, rsp_valid, data_oe, flash_ce_n,
      sram_ce_n, flash_oe_n, flash_we_n, sram_oe_n, sram_we_n}, 10'h03F);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    check("rp_no_supply", {flash_reset_powerdown_n, flash_ready}, 2'h0);
    flash_supply_good = 1'b1;
    n = 0;
    while (flash_reset_powerdown_n !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    check("rp_hold", n > 1 && n < 50, 1);
    wait_flash();
    foreach (rows[i]) access(rows[i]);
    // Park for supply removal: reset pin low, both memories deselected
    flash_power_off_req = 1'b1;
    n = 0;
    while (flash_reset_powerdown_n !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    check("park", {flash_reset_powerdown_n, flash_ce_n, sram_ce_n}, 3'h3);
    check("park_idle", {req_ready, data_oe}, 2'h0);
    flash_power_off_req = 1'b0;
    wait_flash();
    access(rows[3]);
    check("collisions", viol, 0);
    summarize();
  end
endmodule : tb
